// File: sphc_regs.svh
// Constants of the parameter and heating control block.
// Assumes a 25 MHz reference clock and a 17-bit command value field.
`ifndef SPHC_REGS_SVH
`define SPHC_REGS_SVH

// ============================================================
// Clock and timing
`define SPHC_CLK_HZ        25000000
`define SPHC_RAMP_S        125
`define SPHC_FOLLOW_S      3600
`define SPHC_FIRST_TLG_MS  200
`define SPHC_LOADER_MS     1000
`define SPHC_MS_PER_S      1000

// ============================================================
// Value ranges and power-up values
`define SPHC_DUPLEX_MAX    17'h00002
`define SPHC_DUPLEX_INIT   17'h00002
`define SPHC_PATH_MIN      17'h04650
`define SPHC_PATH_MAX      17'h05208
`define SPHC_PATH_INIT     17'h04E20
`define SPHC_ERRSEL_MAX    17'h00004
`define SPHC_SCALE_MAX     17'h00001
`define SPHC_BOOT_MAX      17'h00003
`define SPHC_GUST_MAX      17'h0001E
`define SPHC_VOLT_MIN      17'h00005
`define SPHC_VOLT_MAX      17'h00030
`define SPHC_VOLT_INIT     17'h0000A
`define SPHC_KELV_MIN      17'h000DC
`define SPHC_KELV_MAX      17'h00140
`define SPHC_LOW_INIT      17'h00113
`define SPHC_HIGH_INIT     17'h00118
`define SPHC_HMODE_MAX     17'h00006
`define SPHC_KEY_USER      17'h00001

// ============================================================
// Duplex, forced analog output and boot codes
`define SPHC_DUPLEX_HALF   2'h0
`define SPHC_DUPLEX_RS422  2'h2
`define SPHC_FORCE_NONE    2'h0
`define SPHC_FORCE_ZERO    2'h1
`define SPHC_FORCE_MAX     2'h2
`define SPHC_FORCE_LOW     2'h3
`define SPHC_BOOT_FAST     2'h1
`define SPHC_BOOT_QUIET    2'h2

`endif

// File: sphc_pkg.sv
// Types shared by the parameter and heating control block.
// Assumes a command parser in front that decodes the ASCII telegram.
package sphc_pkg;

	// ============================================================
	// Command codes delivered by the parser
	typedef enum logic [3:0] {
		SPHC_CMD_KEY,
		SPHC_CMD_DUPLEX,
		SPHC_CMD_VERSION,
		SPHC_CMD_PATH_WE,
		SPHC_CMD_PATH_NS,
		SPHC_CMD_ERRSEL,
		SPHC_CMD_SCALE,
		SPHC_CMD_BOOT,
		SPHC_CMD_GUST,
		SPHC_CMD_VOLT,
		SPHC_CMD_POWER,
		SPHC_CMD_LOW,
		SPHC_CMD_HIGH,
		SPHC_CMD_HMODE,
		SPHC_CMD_OTHER
	} sphc_cmd_t;

	// Access levels
	typedef enum logic [1:0] {
		SPHC_ACC_QUERY,
		SPHC_ACC_USER,
		SPHC_ACC_CONFIG
	} sphc_acc_t;

	// Startup sequence
	typedef enum logic [1:0] {
		SPHC_BOOT_START,
		SPHC_BOOT_LOADER,
		SPHC_BOOT_WAIT,
		SPHC_BOOT_MAIN
	} sphc_boot_t;

	// Whole block state
	typedef struct packed {
		sphc_acc_t  acc;
		logic [1:0] duplex;
		logic [16:0] path_we;
		logic [16:0] path_ns;
		logic [2:0] errsel;
		logic       scale;
		logic [1:0] boot_sel;
		logic [4:0] gust;
		logic [5:0] volt_min;
		logic [8:0] low_k;
		logic [8:0] high_k;
		logic [2:0] hmode;
		logic       rsp_valid;
		logic       rsp_ok;
		logic       rsp_ver;
		logic       rsp_unsup;
		logic [16:0] rsp_val;
		logic       need;
		logic [14:0] ms_div;
		logic [9:0] ms_cnt;
		logic       sec_tick;
		logic       ms_tick;
		logic [6:0] ramp;
		logic [6:0] pwm;
		logic [11:0] follow;
		logic       arm_on;
		logic       xd_on;
		sphc_boot_t bst;
		logic [10:0] bcnt;
		logic       loader_tx;
		logic       update_go;
		logic       tlg_ready;
		logic       gust_eval;
	} sphc_state_t;

endpackage

// File: sphc_core.sv
// Parameter store, access control, startup sequencer and heater control.
// Assumes a parser that hands over one decoded command per cmd_valid pulse
// and measurement logic on the same clock.
//
// Contract
// - Three duplex settings steer transmit driver enable
// - Duplex accepts 0..2, powers up at 2
// - Version query answers, changes nothing
// - Two path lengths, 18000..21000, config access
// - Error code picks forced analog output levels
// - Boot code selects loader or fast start
// - Loader announces itself, update on valid reply
// - Gust window 0..30 in 100ms, zero disables
// - Gust reevaluated after every measurement
// - Heating off below supply voltage threshold; the cut applies only when pwr_ctrl_present is set
// - Power query unsupported answers text flag
// - Heating on below lower Kelvin threshold
// - Temperature demand ends above upper threshold
// - Arm heating ramps in pulses over 125s
// - Heating modes 0..6 supported
// - Modes 4,5 transducer one hour follow-up
// - Decisions use last valid measurement
// - Overtemperature cuts heating until cooled
// - Query when value omitted, write otherwise
// - Bad command drops access to query level
`include "sphc_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module sphc_core
	import sphc_pkg::*;
#(
	parameter int MS_TICK_CYC   = `SPHC_CLK_HZ / 1000,  // Cycles per millisecond
	parameter int CONFIG_KEY    = 12345,                // Arbitrary configuration key
	parameter int HMODE_INIT    = 1,                    // Instrument dependent heating mode
	parameter int ERRSEL_INIT   = 0                     // Instrument dependent error code
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Decoded commands
	input  wire logic        cmd_valid,
	input  wire sphc_cmd_t   cmd_code,
	input  wire logic        cmd_has_value,
	input  wire logic [16:0] cmd_value,
	input  wire logic        cmd_bad,
	// Command answers
	output logic             rsp_valid,
	output logic             rsp_ok,
	output logic             rsp_version,
	output logic             rsp_unsupported,
	output logic [16:0]      rsp_value,
	// Serial driver
	input  wire logic        tx_active,
	output logic             tx_drv_en,
	output logic             full_duplex,
	// Measurement side
	input  wire logic        meas_strobe,
	input  wire logic        meas_valid,
	input  wire logic        meas_error,
	input  wire logic [8:0]  virt_temp_k,
	input  wire logic        housing_cold,
	input  wire logic        over_temp,
	output logic [16:0]      path_we_len,
	output logic [16:0]      path_ns_len,
	output logic [4:0]       gust_window,
	output logic             gust_enable,
	output logic             gust_reeval,
	// Analog outputs in error
	output logic [1:0]       spd_force,
	output logic [1:0]       dir_force,
	output logic             output_scaling,
	// Supply and heaters
	input  wire logic        pwr_ctrl_present,
	input  wire logic [5:0]  supply_volts,
	output logic             arm_heat_on,
	output logic             xdcr_heat_on,
	// Startup
	input  wire logic        loader_reply_ok,
	output logic             loader_announce,
	output logic             update_start,
	output logic             start_param_quiet,
	output logic             telegram_ready
);

	// ============================================================
	// Timing counts
	localparam logic [14:0] MS_LAST   = 15'(MS_TICK_CYC - 1);
	localparam logic [9:0]  S_LAST    = 10'(`SPHC_MS_PER_S - 1);
	localparam logic [6:0]  RAMP_FULL = 7'(`SPHC_RAMP_S);
	localparam logic [11:0] FOLLOW_S  = 12'(`SPHC_FOLLOW_S);
	localparam logic [10:0] FAST_MS   = 11'(`SPHC_FIRST_TLG_MS);
	localparam logic [10:0] LOAD_MS   = 11'(`SPHC_LOADER_MS);

	sphc_state_t s_q;  // Registered state
	sphc_state_t s_d;  // Next state

	// Range check for an incoming value
	function automatic logic in_rng(input logic [16:0] v, input logic [16:0] lo,
		input logic [16:0] hi);
		in_rng = (v >= lo) && (v <= hi);
	endfunction

	logic        wr;        // Write request
	logic        ok;        // Command accepted
	logic        okv;       // Value in range
	logic        need_acc;  // Access sufficient
	logic        hv_ok;     // Supply allows heating
	logic        dem_arm;   // Arm demand before gating
	logic        dem_xd;    // Transducer demand before gating
	logic        pulse_on;  // Ramp pulse slot
	logic [16:0] qval;      // Query answer

	// ============================================================
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.rsp_valid = 1'b0;
		s_d.rsp_ver = 1'b0;
		s_d.rsp_unsup = 1'b0;
		s_d.loader_tx = 1'b0;
		s_d.update_go = 1'b0;
		s_d.ms_tick = 1'b0;
		s_d.sec_tick = 1'b0;
		s_d.gust_eval = meas_strobe;
		wr = cmd_has_value;
		okv = 1'b0;
		qval = 17'h00000;
		need_acc = (s_q.acc != SPHC_ACC_QUERY);
		// Value check and current value per command
		case (cmd_code)
			SPHC_CMD_KEY: begin
				okv = (cmd_value <= `SPHC_KEY_USER) || (cmd_value == 17'(CONFIG_KEY));
				qval = {15'h0000, s_q.acc};
				need_acc = 1'b1;
			end
			SPHC_CMD_DUPLEX: begin
				okv = cmd_value <= `SPHC_DUPLEX_MAX;
				qval = {15'h0000, s_q.duplex};
			end
			SPHC_CMD_VERSION: begin
				okv = 1'b0;  // Takes no value
			end
			SPHC_CMD_PATH_WE: begin
				okv = in_rng(cmd_value, `SPHC_PATH_MIN, `SPHC_PATH_MAX);
				qval = s_q.path_we;
				need_acc = (s_q.acc == SPHC_ACC_CONFIG);
			end
			SPHC_CMD_PATH_NS: begin
				okv = in_rng(cmd_value, `SPHC_PATH_MIN, `SPHC_PATH_MAX);
				qval = s_q.path_ns;
				need_acc = (s_q.acc == SPHC_ACC_CONFIG);
			end
			SPHC_CMD_ERRSEL: begin
				okv = cmd_value <= `SPHC_ERRSEL_MAX;
				qval = {14'h0000, s_q.errsel};
			end
			SPHC_CMD_SCALE: begin
				okv = cmd_value <= `SPHC_SCALE_MAX;
				qval = {16'h0000, s_q.scale};
			end
			SPHC_CMD_BOOT: begin
				okv = cmd_value <= `SPHC_BOOT_MAX;
				qval = {15'h0000, s_q.boot_sel};
			end
			SPHC_CMD_GUST: begin
				okv = cmd_value <= `SPHC_GUST_MAX;
				qval = {12'h000, s_q.gust};
			end
			SPHC_CMD_VOLT: begin
				okv = in_rng(cmd_value, `SPHC_VOLT_MIN, `SPHC_VOLT_MAX);
				qval = {11'h000, s_q.volt_min};
			end
			SPHC_CMD_POWER: begin
				okv = 1'b0;  // Query only
				qval = {11'h000, supply_volts};
			end
			SPHC_CMD_LOW: begin
				okv = in_rng(cmd_value, `SPHC_KELV_MIN, `SPHC_KELV_MAX);
				qval = {8'h00, s_q.low_k};
			end
			SPHC_CMD_HIGH: begin
				okv = in_rng(cmd_value, `SPHC_KELV_MIN, `SPHC_KELV_MAX);
				qval = {8'h00, s_q.high_k};
			end
			SPHC_CMD_HMODE: begin
				okv = cmd_value <= `SPHC_HMODE_MAX;
				qval = {14'h0000, s_q.hmode};
			end
			default: begin
				okv = 1'b0;
			end
		endcase
		// Writes need range and access
		ok = !cmd_bad && (cmd_code != SPHC_CMD_OTHER) && (!wr || (okv && need_acc));
		if (cmd_valid) begin
			s_d.rsp_valid = 1'b1;
			s_d.rsp_ok = ok;
			s_d.rsp_val = qval;
			if (!ok) begin
				s_d.acc = SPHC_ACC_QUERY;
			end else if (cmd_code == SPHC_CMD_VERSION) begin
				s_d.rsp_ver = 1'b1;
			end else if (cmd_code == SPHC_CMD_POWER) begin
				s_d.rsp_unsup = !pwr_ctrl_present;
			end else if (wr) begin
				s_d.rsp_val = cmd_value;
				case (cmd_code)
					SPHC_CMD_KEY: begin
						s_d.acc = (cmd_value == 17'h00000) ? SPHC_ACC_QUERY :
							(cmd_value == `SPHC_KEY_USER) ? SPHC_ACC_USER : SPHC_ACC_CONFIG;
					end
					SPHC_CMD_DUPLEX: s_d.duplex = cmd_value[1:0];
					SPHC_CMD_PATH_WE: s_d.path_we = cmd_value;
					SPHC_CMD_PATH_NS: s_d.path_ns = cmd_value;
					SPHC_CMD_ERRSEL: s_d.errsel = cmd_value[2:0];
					SPHC_CMD_SCALE: s_d.scale = cmd_value[0];
					SPHC_CMD_BOOT: s_d.boot_sel = cmd_value[1:0];
					SPHC_CMD_GUST: s_d.gust = cmd_value[4:0];
					SPHC_CMD_VOLT: s_d.volt_min = cmd_value[5:0];
					SPHC_CMD_LOW: s_d.low_k = cmd_value[8:0];
					SPHC_CMD_HIGH: s_d.high_k = cmd_value[8:0];
					SPHC_CMD_HMODE: s_d.hmode = cmd_value[2:0];
					default: s_d.rsp_val = cmd_value;
				endcase
			end
		end

		// Millisecond and second enables from one divider chain
		if (s_q.ms_div == MS_LAST) begin
			s_d.ms_div = 15'h0000;
			s_d.ms_tick = 1'b1;
			if (s_q.ms_cnt == S_LAST) begin
				s_d.ms_cnt = 10'h000;
				s_d.sec_tick = 1'b1;
			end else begin
				s_d.ms_cnt = s_q.ms_cnt + 10'h001;
			end
		end else begin
			s_d.ms_div = s_q.ms_div + 15'h0001;
		end

		// Hysteresis on the latest valid temperature only
		if (meas_valid) begin
			if (virt_temp_k < s_q.low_k) begin
				s_d.need = 1'b1;
			end else if (virt_temp_k > s_q.high_k) begin
				s_d.need = 1'b0;
			end
		end

		// Demand per mode before supply and temperature gating
		dem_arm = 1'b0;
		dem_xd = 1'b0;
		case (s_q.hmode)
			3'h1: begin
				dem_arm = s_q.need;
				dem_xd = s_q.need;
			end
			3'h2, 3'h6: begin
				dem_arm = 1'b1;
				dem_xd = 1'b1;
			end
			3'h3: begin
				dem_arm = s_q.need || housing_cold;
				dem_xd = s_q.need || housing_cold || meas_error;
			end
			3'h4, 3'h5: begin
				dem_arm = s_q.need;
				dem_xd = s_q.need || housing_cold || (s_q.follow != 12'h000);
			end
			default: begin
				dem_arm = 1'b0;
				dem_xd = 1'b0;
			end
		endcase

		// Follow-up restarts while condition holds
		if ((s_q.hmode == 3'h4) || (s_q.hmode == 3'h5)) begin
			if (s_q.need || housing_cold) begin
				s_d.follow = FOLLOW_S;
			end else if (s_q.sec_tick && (s_q.follow != 12'h000)) begin
				s_d.follow = s_q.follow - 12'h001;
			end
		end else begin
			s_d.follow = 12'h000;
		end

		// Supply cut only where the hardware can measure it
		hv_ok = !pwr_ctrl_present || (supply_volts >= s_q.volt_min);

		// Pulsed ramp, one more slot each second
		if (!(dem_arm || dem_xd) || !hv_ok || over_temp) begin
			s_d.ramp = 7'h00;  // Ramp restarts after any pause
		end else if (s_q.sec_tick && (s_q.ramp != RAMP_FULL)) begin
			s_d.ramp = s_q.ramp + 7'h01;
		end
		if (s_q.ms_tick) begin
			s_d.pwm = (s_q.pwm == RAMP_FULL - 7'h01) ? 7'h00 : s_q.pwm + 7'h01;
		end
		pulse_on = (s_q.hmode == 3'h6) || (s_q.ramp == RAMP_FULL) || (s_q.pwm < s_q.ramp);
		s_d.arm_on = dem_arm && hv_ok && !over_temp && pulse_on;
		s_d.xd_on = dem_xd && hv_ok && !over_temp && pulse_on;

		// Startup sequencer
		case (s_q.bst)
			SPHC_BOOT_START: begin
				s_d.bcnt = 11'h000;
				if (s_q.boot_sel == `SPHC_BOOT_FAST) begin
					s_d.bst = SPHC_BOOT_WAIT;
				end else begin
					s_d.bst = SPHC_BOOT_LOADER;
				end
			end
			SPHC_BOOT_LOADER: begin
				s_d.loader_tx = 1'b1;  // Identifying string
				s_d.bst = SPHC_BOOT_WAIT;
			end
			SPHC_BOOT_WAIT: begin
				if ((s_q.boot_sel != `SPHC_BOOT_FAST) && loader_reply_ok) begin
					s_d.update_go = 1'b1;
					s_d.bst = SPHC_BOOT_MAIN;
				end else if (s_q.bcnt == ((s_q.boot_sel == `SPHC_BOOT_FAST) ? FAST_MS : LOAD_MS)) begin
					s_d.tlg_ready = 1'b1;
					s_d.bst = SPHC_BOOT_MAIN;
				end else if (s_q.ms_tick) begin
					s_d.bcnt = s_q.bcnt + 11'h001;
				end
			end
			SPHC_BOOT_MAIN: begin
				s_d.bst = SPHC_BOOT_MAIN;
			end
			default: begin
				s_d.bst = SPHC_BOOT_START;
			end
		endcase
	end

	// ============================================================
	// State register with power-up values
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.acc <= SPHC_ACC_QUERY;
			s_q.duplex <= 2'(`SPHC_DUPLEX_INIT);
			s_q.path_we <= `SPHC_PATH_INIT;
			s_q.path_ns <= `SPHC_PATH_INIT;
			s_q.errsel <= 3'(ERRSEL_INIT);
			s_q.volt_min <= 6'(`SPHC_VOLT_INIT);
			s_q.low_k <= 9'(`SPHC_LOW_INIT);
			s_q.high_k <= 9'(`SPHC_HIGH_INIT);
			s_q.hmode <= 3'(HMODE_INIT);
			s_q.bst <= SPHC_BOOT_START;
		end else begin
			s_q <= s_d;
		end
	end

	// ============================================================
	// Outputs
	assign rsp_valid = s_q.rsp_valid;
	assign rsp_ok = s_q.rsp_ok;
	assign rsp_version = s_q.rsp_ver;
	assign rsp_unsupported = s_q.rsp_unsup;
	assign rsp_value = s_q.rsp_val;
	// Drivers idle off except in the RS422 setting
	assign tx_drv_en = (s_q.duplex == `SPHC_DUPLEX_RS422) || tx_active;
	assign full_duplex = (s_q.duplex != `SPHC_DUPLEX_HALF);
	assign path_we_len = s_q.path_we;
	assign path_ns_len = s_q.path_ns;
	assign gust_window = s_q.gust;
	assign gust_enable = (s_q.gust != 5'h00);
	assign gust_reeval = s_q.gust_eval && gust_enable;
	assign output_scaling = s_q.scale;
	// Code 4 relies on the host having set scaling one
	always_comb begin
		spd_force = `SPHC_FORCE_NONE;
		dir_force = `SPHC_FORCE_NONE;
		if (meas_error) begin
			case (s_q.errsel)
				3'h0: {spd_force, dir_force} = {`SPHC_FORCE_MAX, `SPHC_FORCE_MAX};
				3'h1: {spd_force, dir_force} = {`SPHC_FORCE_ZERO, `SPHC_FORCE_ZERO};
				3'h2: {spd_force, dir_force} = {`SPHC_FORCE_ZERO, `SPHC_FORCE_MAX};
				3'h3: {spd_force, dir_force} = {`SPHC_FORCE_MAX, `SPHC_FORCE_ZERO};
				default: {spd_force, dir_force} = {`SPHC_FORCE_LOW, `SPHC_FORCE_LOW};
			endcase
		end
	end
	assign arm_heat_on = s_q.arm_on;
	assign xdcr_heat_on = s_q.xd_on;
	assign loader_announce = s_q.loader_tx;
	assign update_start = s_q.update_go;
	assign start_param_quiet = (s_q.boot_sel == `SPHC_BOOT_QUIET);
	assign telegram_ready = s_q.tlg_ready;

endmodule

`default_nettype wire

// File: sphc_core_chk.sv
// Assertion checker for the parameter and heating control block.
// Bound into sphc_core; sees its ports only.
`include "sphc_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module sphc_core_chk
	import sphc_pkg::*;
(
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        resetn,
	// Commands and answers
	input wire logic        cmd_valid,
	input wire sphc_cmd_t   cmd_code,
	input wire logic        cmd_has_value,
	input wire logic [16:0] cmd_value,
	input wire logic        cmd_bad,
	input wire logic        rsp_valid,
	input wire logic        rsp_ok,
	input wire logic        rsp_version,
	input wire logic        rsp_unsupported,
	// Serial driver
	input wire logic        tx_active,
	input wire logic        tx_drv_en,
	input wire logic        full_duplex,
	// Measurement, gust and forced outputs
	input wire logic        meas_strobe,
	input wire logic        meas_error,
	input wire logic        over_temp,
	input wire logic [4:0]  gust_window,
	input wire logic        gust_enable,
	input wire logic        gust_reeval,
	input wire logic [1:0]  spd_force,
	input wire logic [1:0]  dir_force,
	// Heaters and startup
	input wire logic        pwr_ctrl_present,
	input wire logic        arm_heat_on,
	input wire logic        xdcr_heat_on,
	input wire logic        loader_reply_ok,
	input wire logic        update_start,
	input wire logic        telegram_ready
);
	// ============================================================
	// Shared timing
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	// Command taken, refusal
	sequence s_take;
		cmd_valid && !cmd_bad;
	endsequence
	sequence s_refuse;
		rsp_valid && !rsp_ok;
	endsequence

	// ============================================================
	// Assertions
	AST_ANSWER: assert property (cmd_valid |=> rsp_valid)
		else $error("no answer");
	AST_BAD_CMD: assert property (cmd_valid && cmd_bad |=> s_refuse)
		else $error("bad command accepted");
	AST_DUPLEX_RANGE: assert property (s_take ##0 cmd_code == SPHC_CMD_DUPLEX
		&& cmd_has_value && cmd_value > `SPHC_DUPLEX_MAX |=> s_refuse ##0 $stable(full_duplex))
		else $error("duplex range not kept");
	AST_DRV_SENDING: assert property (tx_active |-> tx_drv_en)
		else $error("driver off while sending");
	AST_DRV_HALF: assert property (!full_duplex |-> tx_drv_en == tx_active)
		else $error("half duplex driver wrong");
	AST_VERSION: assert property (s_take ##0 cmd_code == SPHC_CMD_VERSION
		&& !cmd_has_value |=> rsp_version && rsp_ok)
		else $error("no version answer");
	AST_UNSUP: assert property (s_take ##0 cmd_code == SPHC_CMD_POWER
		&& !cmd_has_value && !pwr_ctrl_present |=> rsp_unsupported)
		else $error("no unsupported answer");
	AST_NO_FORCE: assert property (!meas_error |-> spd_force == `SPHC_FORCE_NONE
		&& dir_force == `SPHC_FORCE_NONE)
		else $error("analog forced without error");
	AST_OVERTEMP: assert property (over_temp |=> !arm_heat_on && !xdcr_heat_on)
		else $error("heating on at over temperature");
	AST_GUST_EN: assert property (gust_enable == (gust_window != 5'h00))
		else $error("gust enable wrong");
	AST_GUST_EVAL: assert property (meas_strobe && gust_enable |=> gust_reeval)
		else $error("gust not reevaluated");
	AST_UPDATE: assert property (update_start |-> $past(loader_reply_ok) && !telegram_ready)
		else $error("update without loader reply");
endmodule

bind sphc_core sphc_core_chk u_chk (.*);

`default_nettype wire

// File: sphc_host.sv
// Host model: issues decoded commands to the block, one per clock.
// Assumes the testbench calls send and idle.
`timescale 1ns/10ps
`default_nettype none

module sphc_host
	import sphc_pkg::*;
(
	// Clock
	input  wire logic        ref_clk,
	// Command lines
	output var logic         cmd_valid,
	output var sphc_cmd_t    cmd_code,
	output var logic         cmd_has_value,
	output var logic [16:0]  cmd_value,
	output var logic         cmd_bad
);
	// ============================================================
	// Quiet lines at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_code = SPHC_CMD_OTHER;
		cmd_has_value = 1'b0;
		cmd_value = 17'h00000;
		cmd_bad = 1'b0;
	end

	// One command per falling edge
	task automatic send(input sphc_cmd_t c, input logic h, input logic [16:0] v, input logic b);
		@(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_has_value = h;
		cmd_value = v;
		cmd_bad = b;
	endtask

	// Release, flip stale value
	task automatic idle();
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		cmd_value = ~cmd_value;
		cmd_bad = 1'b0;
	endtask
endmodule

`default_nettype wire

// File: sphc_core_tb_top.sv
// Self-checking testbench for the parameter and heating control block.
// Assumes the host model and bound checker alongside.
`include "sphc_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module sphc_core_tb_top
	import sphc_pkg::*;
;
	// ============================================================
	// Signals
	typedef struct {logic ok; logic [16:0] v; logic [1:0] m;} sphc_exp_t;
	localparam logic [16:0] KEY_CFG = 17'h03039; // Config key
	logic ref_clk = 1'b0;
	logic resetn, cmd_valid, cmd_has_value, cmd_bad, rsp_valid, rsp_ok;
	logic rsp_version, rsp_unsupported, tx_active, tx_drv_en, full_duplex;
	logic meas_strobe, meas_valid, meas_error, housing_cold, over_temp;
	logic gust_enable, gust_reeval, output_scaling, pwr_ctrl_present;
	logic arm_heat_on, xdcr_heat_on, loader_reply_ok, loader_announce;
	logic update_start, start_param_quiet, telegram_ready;
	sphc_cmd_t cmd_code;
	logic [16:0] cmd_value, rsp_value, path_we_len, path_ns_len, rv;
	logic [8:0] virt_temp_k;
	logic [5:0] supply_volts;
	logic [4:0] gust_window;
	logic [1:0] spd_force, dir_force;
	sphc_exp_t exp_q[$]; // Expected answers
	int failures = 0;
	int checked = 0;
	integer seed = 53;
	int i;
	// Defaults, forced levels
	sphc_cmd_t qc[7] = '{SPHC_CMD_DUPLEX, SPHC_CMD_PATH_WE, SPHC_CMD_PATH_NS,
		SPHC_CMD_VOLT, SPHC_CMD_LOW, SPHC_CMD_HIGH, SPHC_CMD_GUST};
	logic [16:0] qv[7] = '{`SPHC_DUPLEX_INIT, `SPHC_PATH_INIT, `SPHC_PATH_INIT,
		`SPHC_VOLT_INIT, `SPHC_LOW_INIT, `SPHC_HIGH_INIT, 17'h00000};
	logic [1:0] fs[5] = '{`SPHC_FORCE_MAX, `SPHC_FORCE_ZERO, `SPHC_FORCE_ZERO,
		`SPHC_FORCE_MAX, `SPHC_FORCE_LOW};
	logic [1:0] fd[5] = '{`SPHC_FORCE_MAX, `SPHC_FORCE_ZERO, `SPHC_FORCE_MAX,
		`SPHC_FORCE_ZERO, `SPHC_FORCE_LOW};

	always #20 ref_clk = ~ref_clk;

	// Short millisecond for the run
	sphc_core #(.MS_TICK_CYC(4)) dut (.*);
	sphc_host host (.*);

	// ============================================================
	// Tasks
	task automatic check(input string n, input logic [16:0] s, input logic [16:0] e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// m[0] checks rsp_ok, m[1] rsp_value
	task automatic cmd(input sphc_cmd_t c, input logic h, input logic [16:0] v,
		input logic [1:0] m, input logic ok, input logic [16:0] ev, input logic b = 1'b0);
		exp_q.push_back('{ok, ev, m});
		host.send(c, h, v, b);
	endtask
	task automatic done();
		host.idle();
		repeat (2) @(negedge ref_clk);
	endtask
	task automatic heat(input int n, input logic e);
		repeat (n) @(negedge ref_clk);
		check("arm_heat_on", 17'(arm_heat_on), 17'(e));
	endtask
	task automatic key(input logic [16:0] k);
		cmd(SPHC_CMD_KEY, 1'b1, k, 2'h3, 1'b1, k);
	endtask
	task automatic rst(input logic r);
		resetn = 1'b0;
		loader_reply_ok = r;
		repeat (12) @(negedge ref_clk);
		resetn = 1'b1;
	endtask
	task automatic meas(input logic [8:0] t);
		@(negedge ref_clk);
		{meas_strobe, meas_valid} = 2'h3;
		virt_temp_k = t;
		@(negedge ref_clk);
		{meas_strobe, meas_valid} = 2'h0;
	endtask
	task automatic stop_test();
		$display("Checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ============================================================
	// Answer monitor
	always @(negedge ref_clk) begin
		sphc_exp_t e;
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("rsp_valid", 17'h1, 17'h0);
			end else begin
				e = exp_q.pop_front();
				if (e.m[0]) check("rsp_ok", 17'(rsp_ok), 17'(e.ok));
				if (e.m[1]) check("rsp_value", rsp_value, e.v);
			end
		end
	end

	// Watchdog
	initial begin
		#2000000;
		failures++;
		stop_test();
	end

	// ============================================================
	// Main sequence
	initial begin
		{tx_active, meas_strobe, meas_valid, meas_error, housing_cold, over_temp} = 6'h00;
		virt_temp_k = 9'h113;
		pwr_ctrl_present = 1'b1;
		supply_volts = 6'h18;
		// Loader answered
		rst(1'b1);
		for (i = 0; i < 50 && update_start !== 1'b1; i++) @(negedge ref_clk);
		check("update_start", 17'(update_start), 17'h1);
		repeat (20) @(negedge ref_clk);
		check("telegram_ready", 17'(telegram_ready), 17'h0);
		// Loader timeout
		rst(1'b0);
		for (i = 0; i < 6000 && telegram_ready !== 1'b1; i++) @(negedge ref_clk);
		check("loader_wait", 17'(i >= 3900 && i <= 4100), 17'h1);
		// Power-up values
		for (i = 0; i < 7; i++) cmd(qc[i], 1'b0, 17'h0, 2'h3, 1'b1, qv[i]);
		cmd(SPHC_CMD_GUST, 1'b1, 17'h5, 2'h1, 1'b0, 17'h0);
		key(17'h1);
		rv = 17'((($random(seed) & 32'hFF) % 30) + 1);
		cmd(SPHC_CMD_GUST, 1'b1, rv, 2'h3, 1'b1, rv);
		cmd(SPHC_CMD_GUST, 1'b1, 17'h1E, 2'h3, 1'b1, 17'h1E);
		cmd(SPHC_CMD_GUST, 1'b1, 17'h1F, 2'h1, 1'b0, 17'h0);
		cmd(SPHC_CMD_GUST, 1'b0, 17'h0, 2'h3, 1'b1, 17'h1E);
		done();
		check("gust_window", {12'h0, gust_window}, 17'h1E);
		// Duplex settings steer the driver
		key(17'h1);
		for (i = 0; i < 3; i++) begin
			cmd(SPHC_CMD_DUPLEX, 1'b1, 17'(i), 2'h3, 1'b1, 17'(i));
			done();
			check("tx_drv_en", 17'(tx_drv_en), 17'(i == 2));
			check("full_duplex", 17'(full_duplex), 17'(i != 0));
		end
		tx_active = 1'b1;
		@(negedge ref_clk);
		check("tx_drv_en", 17'(tx_drv_en), 17'h1);
		tx_active = 1'b0;
		cmd(SPHC_CMD_DUPLEX, 1'b1, 17'h3, 2'h1, 1'b0, 17'h0);
		cmd(SPHC_CMD_DUPLEX, 1'b0, 17'h0, 2'h3, 1'b1, 17'h2);
		// Path lengths need configuration access
		key(17'h1);
		cmd(SPHC_CMD_PATH_WE, 1'b1, 17'h04A38, 2'h1, 1'b0, 17'h0);
		key(KEY_CFG);
		cmd(SPHC_CMD_PATH_WE, 1'b1, 17'h04650, 2'h3, 1'b1, 17'h04650);
		cmd(SPHC_CMD_PATH_NS, 1'b1, 17'h05208, 2'h3, 1'b1, 17'h05208);
		cmd(SPHC_CMD_PATH_NS, 1'b1, 17'h05209, 2'h1, 1'b0, 17'h0);
		done();
		check("path_we_len", path_we_len, 17'h04650);
		check("path_ns_len", path_ns_len, 17'h05208);
		// Malformed command drops access
		key(17'h1);
		cmd(SPHC_CMD_GUST, 1'b1, 17'h3, 2'h1, 1'b0, 17'h0, 1'b1);
		cmd(SPHC_CMD_GUST, 1'b1, 17'h3, 2'h1, 1'b0, 17'h0);
		cmd(SPHC_CMD_VERSION, 1'b0, 17'h0, 2'h1, 1'b1, 17'h0);
		cmd(SPHC_CMD_POWER, 1'b0, 17'h0, 2'h3, 1'b1, 17'h18);
		done();
		pwr_ctrl_present = 1'b0;
		cmd(SPHC_CMD_POWER, 1'b0, 17'h0, 2'h0, 1'b0, 17'h0);
		done();
		pwr_ctrl_present = 1'b1;
		check("gust_window", {12'h0, gust_window}, 17'h1E);
		// Forced analog levels per error code
		key(17'h1);
		cmd(SPHC_CMD_SCALE, 1'b1, 17'h1, 2'h3, 1'b1, 17'h1);
		meas_error = 1'b1;
		for (i = 0; i < 5; i++) begin
			cmd(SPHC_CMD_ERRSEL, 1'b1, 17'(i), 2'h3, 1'b1, 17'(i));
			done();
			check("spd_force", 17'(spd_force), 17'(fs[i]));
			check("dir_force", 17'(dir_force), 17'(fd[i]));
		end
		cmd(SPHC_CMD_ERRSEL, 1'b1, 17'h5, 2'h1, 1'b0, 17'h0);
		done();
		check("spd_force", 17'(spd_force), 17'h3);
		meas_error = 1'b0;
		// Boot selection and quiet start
		key(17'h1);
		cmd(SPHC_CMD_BOOT, 1'b1, 17'h2, 2'h3, 1'b1, 17'h2);
		cmd(SPHC_CMD_BOOT, 1'b1, 17'h4, 2'h1, 1'b0, 17'h0);
		done();
		check("start_param_quiet", 17'(start_param_quiet), 17'h1);
		// Unramped heating
		key(17'h1);
		cmd(SPHC_CMD_HMODE, 1'b1, 17'h7, 2'h1, 1'b0, 17'h0);
		key(17'h1);
		cmd(SPHC_CMD_HMODE, 1'b1, 17'h6, 2'h3, 1'b1, 17'h6);
		done();
		heat(0, 1'b1);
		over_temp = 1'b1;
		heat(2, 1'b0);
		over_temp = 1'b0;
		heat(3, 1'b1);
		supply_volts = 6'h09;
		heat(3, 1'b0);
		supply_volts = 6'h0A;
		heat(3, 1'b1);
		// Pulsed ramp
		key(17'h1);
		cmd(SPHC_CMD_HMODE, 1'b1, 17'h1, 2'h3, 1'b1, 17'h1);
		done();
		meas(9'(220 + (($random(seed) & 32'hFF) % 55)));
		for (i = 0; i < 6000 && arm_heat_on !== 1'b1; i++) @(negedge ref_clk);
		heat(0, 1'b1);
		heat(10, 1'b0);
		meas(9'(281 + (($random(seed) & 32'hFF) % 39)));
		for (i = 0; i < 600 && arm_heat_on !== 1'b1; i++) @(negedge ref_clk);
		check("heat_ended", 17'(i == 600), 17'h1);
		stop_test();
	end
endmodule

`default_nettype wire
